// [hdl/ssac_pkg.sv]
/*
 * Shared constants, carriers and the quadrant lookup for the serial step angle control block.
 * Assumes a 16-bit serial frame, most significant bit first, with a two-bit register select on top.
 */
package ssac_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_LAST = 5'h0f;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam logic [1:0] ADDR_RUN = 2'h3;
    localparam logic [1:0] ADDR_TABLE = 2'h2;
    localparam int DELTA_HI = 5;
    localparam int DELTA_LO = 0;
    localparam int CFG_HI = 13;
    localparam int CFG_LO = 6;
    localparam int CFG_W = 8;
    localparam int TIDX_HI = 9;
    localparam int TIDX_LO = 6;
    localparam int TVAL_HI = 5;
    localparam int TVAL_LO = 0;

    // ------------------------------------------------------------
    // Position and table
    // ------------------------------------------------------------
    localparam int ANGLE_W = 6;
    localparam int DAC_W = 6;
    localparam int PT_DEPTH = 16;
    localparam int PT_AW = 4;
    localparam logic [5:0] ANGLE_MAX = 6'h3f;
    localparam logic [5:0] ANGLE_ONE = 6'h01;
    localparam logic [5:0] ANGLE_ZERO = 6'h00;
    localparam logic [5:0] QUARTER_SHIFT = 6'h10;
    localparam logic [4:0] QPOS_ZERO_A = 5'h00;
    localparam logic [4:0] QPOS_ZERO_B = 5'h10;
    localparam logic [5:0] DAC_ZERO = 6'h00;
    localparam logic [3:0] IDX_ZERO = 4'h0;
    localparam logic [3:0] IDX_ONE = 4'h1;
    // Default sinusoidal quarter: peak value on top, first value at bits 5:0
    localparam logic [95:0] PT_DEFAULT = {6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h3a, 6'h37, 6'h34, 6'h30,
                                          6'h2c, 6'h28, 6'h23, 6'h1d, 6'h17, 6'h12, 6'h0b, 6'h05};

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rev;
        logic [5:0] dac;
    } ssac_drive_s;

    typedef struct packed {
        logic zero;
        logic rev;
        logic [3:0] idx;
    } ssac_look_s;

    // ------------------------------------------------------------
    // Position to table entry
    // ------------------------------------------------------------
    function automatic ssac_look_s ssac_lookup(input logic [5:0] angle);
        ssac_look_s r;
        r.rev = angle[5];
        r.zero = !angle[4] && (angle[3:0] == IDX_ZERO);
        r.idx = angle[4] ? ~angle[3:0] : angle[3:0] - IDX_ONE;
        return r;
    endfunction : ssac_lookup

endpackage : ssac_pkg

// [hdl/ssac_phase_table.sv]
/*
 * Programmable phase current table with one write port and two registered read ports.
 * Assumes write and reads on the core clock; resets to the default sinusoidal quarter.
 */
`timescale 1ns/10ps
module ssac_phase_table #(
    parameter int DEPTH = ssac_pkg::PT_DEPTH,
    parameter int AW = ssac_pkg::PT_AW,
    parameter int W = ssac_pkg::DAC_W,
    parameter logic [DEPTH*W-1:0] INIT = ssac_pkg::PT_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [W-1:0] wr_val,
    input wire logic [AW-1:0] rd_idx_a,
    input wire logic [AW-1:0] rd_idx_b,
    output logic [W-1:0] rd_a,
    output logic [W-1:0] rd_b
);
    import ssac_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rd_a;
        logic [W-1:0] rd_b;
    } ssac_tbl_s;

    ssac_tbl_s st;
    ssac_tbl_s next_st;

    always_comb begin
        next_st = st;
        if (ce) begin
            next_st.rd_a = st.mem[rd_idx_a];
            next_st.rd_b = st.mem[rd_idx_b];
            if (wr_en) begin
                next_st.mem[wr_idx] = wr_val;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{mem: INIT, rd_a: '0, rd_b: '0};
        end else begin
            st <= next_st;
        end
    end

    assign rd_a = st.rd_a;
    assign rd_b = st.rd_b;

    property p_table_write;
        @(posedge clk) disable iff (!rst_b)
        ce && wr_en ##1 ce && rd_idx_a == $past(wr_idx) |=> rd_a == $past(wr_val, 2);
    endproperty
    a_table_write: assert property (p_table_write) else $error("table entry not updated");

endmodule : ssac_phase_table

// [hdl/ssac_top.sv]
/*
 * Serial step angle control: frame receiver on the serial clock, position and phase drive on CLK.
 * Assumes the serial clock runs only inside frames and the strobe rises after the last serial edge.
 */
`timescale 1ns/10ps
module ssac_top (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic SCK,
    input wire logic SERIAL_FRAME_STROBE_LOW,
    input wire logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic [ssac_pkg::ANGLE_W-1:0] STEP_ANGLE,
    output logic [ssac_pkg::CFG_W-1:0] RUN_CFG,
    output ssac_pkg::ssac_drive_s PHASE_A,
    output ssac_pkg::ssac_drive_s PHASE_B
);
    import ssac_pkg::*;

    // ------------------------------------------------------------
    // Link side state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [FRAME_BITS-1:0] shift;
    } ssac_link_s;

    typedef struct packed {
        logic [FRAME_BITS-1:0] word;
        logic tog;
    } ssac_word_s;

    ssac_link_s lk;
    ssac_link_s next_lk;
    ssac_word_s lw;
    ssac_word_s next_lw;
    logic link_rst_b;

    assign link_rst_b = RST_B && !SERIAL_FRAME_STROBE_LOW;

    always_comb begin
        next_lk = lk;
        next_lw = lw;
        next_lk.shift = {lk.shift[FRAME_BITS-2:0], SERIAL_DATA_IN};
        if (lk.count != CNT_FULL) begin
            next_lk.count = lk.count + CNT_ONE;
        end
        if (lk.count == CNT_LAST) begin
            next_lw.word = {lk.shift[FRAME_BITS-2:0], SERIAL_DATA_IN};
            next_lw.tog = !lw.tog;
        end
    end

    // Counter restarts with every frame, so SCK speed never matters
    always_ff @(posedge SCK or negedge link_rst_b) begin
        if (!link_rst_b) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    always_ff @(posedge SCK or negedge RST_B) begin
        if (!RST_B) begin
            lw <= '0;
        end else begin
            lw <= next_lw;
        end
    end

    assign SERIAL_DATA_OUT = lk.shift[FRAME_BITS-1];

    // ------------------------------------------------------------
    // Core side state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] strb_sync;
        logic strb_prev;
        logic [1:0] tog_sync;
        logic tog_seen;
        logic [ANGLE_W-1:0] angle;
        logic [CFG_W-1:0] run_cfg;
        ssac_look_s look_a;
        ssac_look_s look_b;
        ssac_drive_s drv_a;
        ssac_drive_s drv_b;
    } ssac_core_s;

    ssac_core_s st;
    ssac_core_s next_st;
    logic strobe_rise;
    logic apply_run;
    logic apply_table;
    logic [ANGLE_W-1:0] run_delta;
    ssac_look_s now_a;
    ssac_look_s now_b;
    logic [DAC_W-1:0] tbl_a;
    logic [DAC_W-1:0] tbl_b;

    always_comb begin
        next_st = st;
        strobe_rise = st.strb_sync[2] && !st.strb_prev;
        apply_run = 1'b0;
        apply_table = 1'b0;
        run_delta = lw.word[DELTA_HI:DELTA_LO];
        now_a = ssac_lookup(st.angle);
        now_b = ssac_lookup(st.angle + QUARTER_SHIFT);
        if (CE) begin
            next_st.strb_sync = {st.strb_sync[1:0], SERIAL_FRAME_STROBE_LOW};
            next_st.strb_prev = st.strb_sync[2];
            next_st.tog_sync = {st.tog_sync[0], lw.tog};
            // Word is quiet once the strobe is high, so it is read directly
            if (strobe_rise && (st.tog_sync[1] != st.tog_seen)) begin
                next_st.tog_seen = st.tog_sync[1];
                apply_run = lw.word[ADDR_HI:ADDR_LO] == ADDR_RUN;
                apply_table = lw.word[ADDR_HI:ADDR_LO] == ADDR_TABLE;
            end
            if (apply_run) begin
                next_st.angle = st.angle + run_delta;
                next_st.run_cfg = lw.word[CFG_HI:CFG_LO];
            end
            next_st.look_a = now_a;
            next_st.look_b = now_b;
            next_st.drv_a.rev = st.look_a.rev;
            next_st.drv_a.dac = st.look_a.zero ? DAC_ZERO : tbl_a;
            next_st.drv_b.rev = st.look_b.rev;
            next_st.drv_b.dac = st.look_b.zero ? DAC_ZERO : tbl_b;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= '{strb_sync: '1, strb_prev: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Phase current table
    // ------------------------------------------------------------
    ssac_phase_table u_table (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .wr_en(apply_table),
        .wr_idx(lw.word[TIDX_HI:TIDX_LO]),
        .wr_val(lw.word[TVAL_HI:TVAL_LO]),
        .rd_idx_a(now_a.idx),
        .rd_idx_b(now_b.idx),
        .rd_a(tbl_a),
        .rd_b(tbl_b)
    );

    assign STEP_ANGLE = st.angle;
    assign RUN_CFG = st.run_cfg;
    assign PHASE_A = st.drv_a;
    assign PHASE_B = st.drv_b;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_update;
        @(posedge CLK) disable iff (!RST_B)
        apply_run |=> st.angle == $past(st.angle) + $past(run_delta);
    endproperty
    a_update: assert property (p_update) else $error("position not advanced by step change");

    property p_wrap_up;
        @(posedge CLK) disable iff (!RST_B)
        apply_run && st.angle == ANGLE_MAX && run_delta == ANGLE_ONE |=> st.angle == ANGLE_ZERO;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("upward wrap wrong");

    property p_wrap_down;
        @(posedge CLK) disable iff (!RST_B)
        apply_run && st.angle == ANGLE_ZERO && run_delta == ANGLE_MAX |=> st.angle == ANGLE_MAX;
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("downward wrap wrong");

    property p_hold;
        @(posedge CLK) disable iff (!RST_B)
        !apply_run |=> $stable(st.angle) && $stable(RUN_CFG);
    endproperty
    a_hold: assert property (p_hold) else $error("position moved without strobe");

    property p_zero_step;
        @(posedge CLK) disable iff (!RST_B)
        apply_run && run_delta == ANGLE_ZERO |=> $stable(STEP_ANGLE);
    endproperty
    a_zero_step: assert property (p_zero_step) else $error("zero step moved position");

    property p_rate;
        @(posedge CLK) disable iff (!RST_B)
        apply_run |-> CE && st.strb_sync[2] && !st.strb_prev && $past(!st.strb_sync[2]);
    endproperty
    a_rate: assert property (p_rate) else $error("step not tied to strobe edge");

    property p_cfg;
        @(posedge CLK) disable iff (!RST_B)
        apply_run |=> RUN_CFG == $past(lw.word[CFG_HI:CFG_LO]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("run configuration not taken");

    property p_a_zero;
        @(posedge CLK) disable iff (!RST_B)
        CE && st.angle[4:0] == QPOS_ZERO_A ##1 CE ##1 CE |-> PHASE_A.dac == DAC_ZERO
            && PHASE_A.rev == $past(st.angle[5], 2);
    endproperty
    a_a_zero: assert property (p_a_zero) else $error("phase A not zero at crossing");

    property p_b_zero;
        @(posedge CLK) disable iff (!RST_B)
        CE && st.angle[4:0] == QPOS_ZERO_B ##1 CE ##1 CE |-> PHASE_B.dac == DAC_ZERO
            && PHASE_B.rev == !$past(st.angle[5], 2);
    endproperty
    a_b_zero: assert property (p_b_zero) else $error("phase B offset wrong");

    c_forward: cover property (@(posedge CLK) disable iff (!RST_B) apply_run && !run_delta[DELTA_HI]);
    c_reverse: cover property (@(posedge CLK) disable iff (!RST_B) apply_run && run_delta[DELTA_HI]);
    c_wrap: cover property (@(posedge CLK) disable iff (!RST_B)
        apply_run && st.angle == ANGLE_MAX && run_delta == ANGLE_ONE);
    c_table: cover property (@(posedge CLK) disable iff (!RST_B) apply_table);

endmodule : ssac_top

// [test/ssac_host_model.sv]
/*
 * Host model for the serial link: sends frames of up to 16 bits at a chosen serial clock rate.
 * Assumes the device samples data on the rising serial edge and the frame ends at strobe rise.
 */
`timescale 1ns/10ps
module ssac_host_model (
    output logic sck,
    output logic strobe_low,
    output logic sdi
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        sck = 1'b0;
        strobe_low = 1'b1;
        sdi = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame sender, serial clock still outside frames
    // ------------------------------------------------------------
    task automatic send(input logic [15:0] word, input int nbits, input int half);
        int i;
        strobe_low = 1'b0;
        #(half + 3.3);
        for (i = 0; i < nbits; i++) begin
            sdi = word[15 - i];
            #(half) sck = 1'b1;
            #(half) sck = 1'b0;
        end
        #(half);
        strobe_low = 1'b1;
        sdi = ~sdi;
    endtask : send
endmodule : ssac_host_model

// [test/tb_top.sv]
/*
 * Self-checking bench for the serial step angle control block.
 * Assumes the host model sends frames; expectations come from the default table, updated on each table write, and bench functions.
 */
`timescale 1ns/10ps
module tb_top;
    import ssac_pkg::*;
    logic clk, rst_b, ce, sck, strb_low, sdi, sdo;
    logic [5:0] angle, exp_ang, d;
    logic [7:0] cfg, exp_cfg;
    ssac_drive_s pha, phb;
    logic [5:0] tbl [16];
    logic [15:0] lfsr;
    int miscompares, checks, i;
    logic [15:0] sr_exp = 16'h0000;

    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ssac_top uut (.CLK(clk), .RST_B(rst_b), .CE(ce), .SCK(sck), .SERIAL_FRAME_STROBE_LOW(strb_low),
        .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .STEP_ANGLE(angle), .RUN_CFG(cfg),
        .PHASE_A(pha), .PHASE_B(phb));

    ssac_host_model host (.sck(sck), .strobe_low(strb_low), .sdi(sdi));

    always @(posedge sck or posedge strb_low) begin
        if (strb_low) begin
            sr_exp <= 16'h0000;
        end else begin
            sr_exp <= {sr_exp[14:0], sdi};
        end
    end

    always @(negedge sck) begin
        check("serial_data_out", {7'h0, sr_exp[15]}, {7'h0, sdo});
    end

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    function automatic ssac_drive_s phase_exp(input logic [5:0] a);
        ssac_drive_s r;
        r.rev = a[5];
        if (a[4]) begin
            r.dac = tbl[4'hf - a[3:0]];
        end else if (a[3:0] == 4'h0) begin
            r.dac = 6'h00;
        end else begin
            r.dac = tbl[a[3:0] - 4'h1];
        end
        return r;
    endfunction : phase_exp

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic tally_and_finish;
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic frame(input logic [15:0] w, input int n, input int half);
        host.send(w, n, half);
        check("angle_at_strobe", {2'h0, exp_ang}, {2'h0, angle});
        if (n == 16 && w[15:14] == 2'h3) begin
            exp_ang = exp_ang + w[5:0];
            exp_cfg = w[13:6];
        end
        if (n == 16 && w[15:14] == 2'h2) begin
            tbl[w[9:6]] = w[5:0];
        end
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("step_angle", {2'h0, exp_ang}, {2'h0, angle});
        check("run_cfg", exp_cfg, cfg);
        check("phase_a", {1'b0, phase_exp(exp_ang)}, {1'b0, pha});
        check("phase_b", {1'b0, phase_exp(exp_ang + 6'h10)}, {1'b0, phb});
    endtask : frame

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        exp_ang = 6'h00;
        exp_cfg = 8'h00;
        d = 6'h00;
        lfsr = 16'h111d;
        miscompares = 0;
        checks = 0;
        for (i = 0; i < 16; i++) begin
            tbl[i] = PT_DEFAULT[i * 6 +: 6];
        end
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        frame({2'h3, 8'h00, 6'h00}, 16, 15);
        frame({2'h3, 8'ha5, 6'h3f}, 16, 15);
        frame({2'h3, 8'h5a, 6'h02}, 16, 15);
        frame({2'h3, 8'h5a, 6'h3e}, 16, 15);
        frame({2'h3, 8'h5a, 6'h01}, 16, 15);
        frame({2'h3, 8'h81, 6'h20}, 16, 15);
        for (i = 0; i < 8; i++) begin
            d = 6'h10 >> i[1:0];
            frame({2'h3, 8'h3c, i[2] ? -d : d}, 16, 15);
        end
        frame({2'h3, 8'hff, 6'h05}, 15, 15);
        frame({2'h1, 8'hff, 6'h05}, 16, 15);
        for (i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            frame({2'h2, 4'h0, lfsr[9:0]}, 16, 15);
            d = {2'h0, lfsr[9:6]} + 6'h01 - exp_ang;
            frame({2'h3, 8'h00, d}, 16, 15);
        end
        frame({2'h2, 4'h0, exp_ang[3:0] - 4'h1, 6'h2a}, 16, 15);
        host.send({2'h3, 8'h66, 6'h07}, 16, 15);
        @(negedge clk);
        ce = 1'b0;
        repeat (8) @(negedge clk);
        check("angle_frozen", {2'h0, exp_ang}, {2'h0, angle});
        ce = 1'b1;
        exp_ang = exp_ang + 6'h07;
        exp_cfg = 8'h66;
        repeat (8) @(negedge clk);
        frame({2'h3, 8'h66, 6'h00}, 16, 15);
        for (i = 0; i < 40; i++) begin
            lfsr = lfsr_next(lfsr);
            frame({2'h3, lfsr[13:0]}, 16, lfsr[15] ? 40 : 15);
        end
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    initial begin
        #3000000;
        miscompares++;
        tally_and_finish();
    end
endmodule : tb_top
